// >>> rtl/spd_pkg.sv
// shared constants and types for the single-precision legality decoder
package spd_pkg;

   // ==========================================================
   // field widths
   localparam int REG_NUM_W = 5;
   localparam int MISC_OPC_W = 4;
   localparam int OPTION_W = 4;
   localparam int SELECT_W = 2;
   localparam int REG_FIELDS = 3;

   // ==========================================================
   // register file shape
   localparam logic [REG_NUM_W-1:0] DREG_LAST = 5'h0F;
   localparam logic SIXTEEN_DREG_VARIANT = 1'b1;
   localparam logic DOUBLE_PREC_SUPPORTED = 1'b0;

   // ==========================================================
   // encoding forms, as a mask: bit 0 first form, bit 1 second form
   localparam int FORM_W = 2;
   localparam logic [FORM_W-1:0] FORM_FIRST = 2'h1;
   localparam logic [FORM_W-1:0] FORM_SECOND = 2'h2;
   localparam logic [FORM_W-1:0] FORM_BOTH = 2'h3;

   // ==========================================================
   // move selector patterns: value and care mask
   localparam logic [3:0] MOVE_SEL_VALUE = 4'h0;
   localparam logic [3:0] MOVE_SEL_CARE = 4'hB;
   localparam logic MOVE_UNSIGNED_VALUE = 1'b0;

   // ==========================================================
   // miscellaneous system opcodes
   localparam logic [MISC_OPC_W-1:0] OPC_CLEAR_EXCLUSIVE = 4'h2;
   localparam logic [MISC_OPC_W-1:0] OPC_DATA_SYNC = 4'h4;
   localparam logic [MISC_OPC_W-1:0] OPC_MEMORY_ORDER = 4'h5;
   localparam logic [MISC_OPC_W-1:0] OPC_INSTR_SYNC = 4'h6;
   localparam logic [OPTION_W-1:0] OPTION_FULL_SYSTEM = 4'hF;

   // ==========================================================
   // reset values
   localparam logic [OPTION_W-1:0] OPTION_RESET = 4'h0;

   typedef enum logic [1:0] {
      CLASS_OTHER,
      CLASS_FLOAT,
      CLASS_MISC_SYSTEM
   } spd_class_t;

   // floating-point families as identified by fetch
   typedef enum logic [5:0] {
      FP_ABSOLUTE, FP_ADD, FP_COMPARE, FP_CONVERT_INT, FP_CONVERT_FIXED,
      FP_CONVERT_DIRECTED, FP_CONVERT_HALF, FP_DIVIDE, FP_FUSED_MAC, FP_FUSED_NEG_MAC,
      FP_LOAD_MULTI, FP_LOAD_SINGLE, FP_MAX_MIN, FP_MUL_ACCUMULATE, FP_MOVE_IMMEDIATE,
      FP_MOVE_REGISTER, FP_MOVE_GPR_TO_SCALAR, FP_MOVE_SCALAR_TO_GPR, FP_MOVE_GPR_SINGLE,
      FP_MOVE_GPR_PAIR_SINGLES, FP_MOVE_GPR_PAIR_DOUBLE, FP_READ_STATUS, FP_WRITE_STATUS,
      FP_MULTIPLY, FP_NEGATE, FP_NEG_MULTIPLY, FP_POP, FP_PUSH, FP_ROUND_DIRECTED,
      FP_ROUND_EXACT, FP_ROUND_ZERO, FP_SELECT_COND, FP_SQUARE_ROOT, FP_STORE_MULTI,
      FP_STORE_SINGLE, FP_SUBTRACT, FP_UNLISTED
   } spd_fp_op_t;

   // what goes to execute
   typedef enum logic [2:0] {
      ISSUE_NONE,
      ISSUE_PASS,
      ISSUE_FLOAT,
      ISSUE_CLEAR_EXCLUSIVE,
      ISSUE_DATA_SYNC,
      ISSUE_MEMORY_ORDER,
      ISSUE_INSTR_SYNC
   } spd_issue_t;

endpackage

// >>> rtl/spd_legality_decoder.sv
// legality check and classification of fetched instructions for a single-precision core
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Overview of operation
// - double-precision operations are rejected; only single-precision arithmetic is accepted.
// - exactly sixteen doubleword registers exist, numbered zero to fifteen.
// - any doubleword register operand above fifteen makes the encoding undefined.
// - only listed floating encodings are accepted; anything else is not implemented.
// - integer-to-float conversion and its rounded variant need size bit zero.
// - float/fixed conversion only in first form with size bit zero.
// - multiply-accumulate and multiply-subtract, second form, need size bit zero.
// - directed round-to-integral operations need size bit zero.
// - conditional selects accepted in first form only with size bit zero.
// - general register to scalar move needs selector fields matching 0x00.
// - scalar to general register move needs unsigned flag clear and selectors matching 0x00.
// - general register to single register move accepted in first form unless a flagged doubleword register is above fifteen.
// - register pair to single pair move accepted in first form unless a flagged doubleword register is above fifteen.
// - register pair to doubleword move accepted in first form unless a flagged doubleword register is above fifteen.
// - misc opcode 0010 clear, 0100 data sync, 0101 order, 0110 instr sync.
// - memory order barrier option is four bits, full system is all ones.
module spd_legality_decoder (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // instruction from fetch
   input wire logic instrValid,
   input wire spd_pkg::spd_class_t instrClass,
   input wire spd_pkg::spd_fp_op_t fpOp,
   input wire logic [spd_pkg::FORM_W-1:0] encForm,
   input wire logic size_bit,
   input wire logic unsignedFlag,
   input wire logic [spd_pkg::SELECT_W-1:0] first_select_field,
   input wire logic [spd_pkg::SELECT_W-1:0] second_select_field,
   input wire logic [spd_pkg::REG_FIELDS*spd_pkg::REG_NUM_W-1:0] regNums,
   input wire logic [spd_pkg::REG_FIELDS-1:0] regIsDouble,
   input wire logic [spd_pkg::MISC_OPC_W-1:0] miscOpcode,
   input wire logic [spd_pkg::OPTION_W-1:0] barrierOption,
   // toward execute
   output logic issueValid,
   output spd_pkg::spd_issue_t issueOp,
   output logic [spd_pkg::OPTION_W-1:0] issueOption,
   output logic fullSystemBarrier,
   output logic undefExc,
   // static capability
   output logic sixteen_dreg_variant,
   output logic doublePrecSupported
);
   import spd_pkg::*;

   // ==========================================================
   // helpers
   // fetch hands over the form as a mask, so a form test is a plain and
   function automatic logic formIn(input logic [FORM_W-1:0] form, input logic [FORM_W-1:0] allowed);
      formIn = (form & allowed) != 2'h0;
   endfunction

   function automatic logic selectMatch(input logic [SELECT_W-1:0] a, input logic [SELECT_W-1:0] b);
      selectMatch = (({a, b} & MOVE_SEL_CARE) == MOVE_SEL_VALUE);
   endfunction

   // ==========================================================
   // floating legality
   logic fpAccept;
   logic regOutOfRange;
   logic single;
   integer i;

   // range check runs on every flagged field, moves included, so a high register never slips through
   always_comb begin
      single = (size_bit == 1'b0);
      regOutOfRange = 1'b0;
      for (i = 0; i < REG_FIELDS; i = i + 1) begin
         // only sixteen doubleword registers exist
         if (regIsDouble[i] && (regNums[i*REG_NUM_W +: REG_NUM_W] > DREG_LAST)) begin
            regOutOfRange = 1'b1;
         end
      end
      case (fpOp)
         FP_ABSOLUTE, FP_ADD, FP_FUSED_MAC, FP_MAX_MIN, FP_MOVE_IMMEDIATE, FP_MOVE_REGISTER,
         FP_MULTIPLY, FP_NEGATE: begin
            fpAccept = formIn(encForm, FORM_SECOND) && single;
         end
         FP_COMPARE, FP_NEG_MULTIPLY: begin
            fpAccept = formIn(encForm, FORM_BOTH) && single;
         end
         FP_CONVERT_INT: begin
            fpAccept = formIn(encForm, FORM_FIRST) && single;
         end
         FP_CONVERT_FIXED: begin
            fpAccept = formIn(encForm, FORM_FIRST) && single;
         end
         FP_MUL_ACCUMULATE: begin
            fpAccept = formIn(encForm, FORM_SECOND) && single;
         end
         FP_ROUND_DIRECTED: begin
            fpAccept = formIn(encForm, FORM_FIRST) && single;
         end
         FP_SELECT_COND: begin
            fpAccept = formIn(encForm, FORM_FIRST) && single;
         end
         FP_CONVERT_DIRECTED, FP_CONVERT_HALF, FP_DIVIDE, FP_FUSED_NEG_MAC, FP_ROUND_EXACT,
         FP_ROUND_ZERO, FP_SQUARE_ROOT, FP_SUBTRACT: begin
            fpAccept = formIn(encForm, FORM_FIRST) && single;
         end
         FP_MOVE_GPR_TO_SCALAR: begin
            fpAccept = formIn(encForm, FORM_FIRST)
                       && selectMatch(first_select_field, second_select_field);
         end
         FP_MOVE_SCALAR_TO_GPR: begin
            fpAccept = formIn(encForm, FORM_FIRST) && (unsignedFlag == MOVE_UNSIGNED_VALUE)
                       && selectMatch(first_select_field, second_select_field);
         end
         FP_MOVE_GPR_SINGLE: begin
            fpAccept = formIn(encForm, FORM_FIRST);
         end
         FP_MOVE_GPR_PAIR_SINGLES: begin
            fpAccept = formIn(encForm, FORM_FIRST);
         end
         FP_MOVE_GPR_PAIR_DOUBLE: begin
            fpAccept = formIn(encForm, FORM_FIRST);
         end
         FP_READ_STATUS, FP_WRITE_STATUS: begin
            fpAccept = formIn(encForm, FORM_FIRST);
         end
         FP_LOAD_MULTI, FP_LOAD_SINGLE, FP_POP, FP_PUSH, FP_STORE_MULTI, FP_STORE_SINGLE: begin
            fpAccept = formIn(encForm, FORM_BOTH);
         end
         default: begin
            fpAccept = 1'b0;
         end
      endcase
      if (regOutOfRange) begin
         fpAccept = 1'b0;
      end
   end

   // ==========================================================
   // miscellaneous system class
   spd_issue_t miscOp;

   // option rides along on every allocated op; execute ignores it where unused
   always_comb begin
      case (miscOpcode)
         OPC_CLEAR_EXCLUSIVE: miscOp = ISSUE_CLEAR_EXCLUSIVE;
         OPC_DATA_SYNC: miscOp = ISSUE_DATA_SYNC;
         OPC_MEMORY_ORDER: miscOp = ISSUE_MEMORY_ORDER;
         OPC_INSTR_SYNC: miscOp = ISSUE_INSTR_SYNC;
         default: miscOp = ISSUE_NONE;
      endcase
   end

   // ==========================================================
   // issue stage
   // one register stage so accept and exception leave together, never skewed
   logic next_issueValid;
   spd_issue_t next_issueOp;
   logic [OPTION_W-1:0] next_issueOption;
   logic next_fullSystemBarrier;
   logic next_undefExc;

   always_comb begin
      next_issueValid = 1'b0;
      next_issueOp = ISSUE_NONE;
      next_issueOption = OPTION_RESET;
      next_fullSystemBarrier = 1'b0;
      next_undefExc = 1'b0;
      if (instrValid) begin
         case (instrClass)
            CLASS_FLOAT: begin
               next_issueValid = fpAccept;
               next_issueOp = fpAccept ? ISSUE_FLOAT : ISSUE_NONE;
               next_undefExc = !fpAccept;
            end
            CLASS_MISC_SYSTEM: begin
               next_issueValid = (miscOp != ISSUE_NONE);
               next_issueOp = miscOp;
               next_undefExc = (miscOp == ISSUE_NONE);
               if (miscOp != ISSUE_NONE) begin
                  next_issueOption = barrierOption;
               end
               if (miscOp == ISSUE_MEMORY_ORDER) begin
                  next_fullSystemBarrier = (barrierOption == OPTION_FULL_SYSTEM);
               end
            end
            default: begin
               // other classes are decoded elsewhere; pass through untouched
               next_issueValid = 1'b1;
               next_issueOp = ISSUE_PASS;
            end
         endcase
      end
   end

   // outputs clear on reset so execute never sees a stale issue
   always_ff @(posedge core_clk) begin
      if (rst) begin
         issueValid <= 1'b0;
         issueOp <= ISSUE_NONE;
         issueOption <= OPTION_RESET;
         fullSystemBarrier <= 1'b0;
         undefExc <= 1'b0;
      end else begin
         issueValid <= next_issueValid;
         issueOp <= next_issueOp;
         issueOption <= next_issueOption;
         fullSystemBarrier <= next_fullSystemBarrier;
         undefExc <= next_undefExc;
      end
   end

   // ==========================================================
   // capability flags
   assign sixteen_dreg_variant = SIXTEEN_DREG_VARIANT;
   assign doublePrecSupported = DOUBLE_PREC_SUPPORTED;

endmodule

`default_nettype wire

// >>> testbench/spd_legality_decoder_asserts.sv
// concurrent checks on the legality decoder ports
`timescale 1ns/1ps
`default_nettype none
module spd_legality_decoder_asserts
   import spd_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // instruction from fetch
   input wire logic instrValid,
   input wire spd_pkg::spd_class_t instrClass,
   input wire spd_pkg::spd_fp_op_t fpOp,
   input wire logic size_bit,
   input wire logic [spd_pkg::REG_FIELDS*spd_pkg::REG_NUM_W-1:0] regNums,
   input wire logic [spd_pkg::REG_FIELDS-1:0] regIsDouble,
   input wire logic [spd_pkg::MISC_OPC_W-1:0] miscOpcode,
   input wire logic [spd_pkg::OPTION_W-1:0] barrierOption,
   // toward execute
   input wire logic issueValid,
   input wire spd_pkg::spd_issue_t issueOp,
   input wire logic fullSystemBarrier,
   input wire logic undefExc,
   input wire logic sixteen_dreg_variant,
   input wire logic doublePrecSupported
);
   // ==========
   // checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_fp; instrValid && instrClass == CLASS_FLOAT; endsequence
   sequence s_misc; instrValid && instrClass == CLASS_MISC_SYSTEM; endsequence
   property p_answer; instrValid |=> $onehot({issueValid, undefExc}); endproperty
   a_answer: assert property (p_answer) else $error("no single answer");
   property p_idle; !instrValid |=> !issueValid && !undefExc; endproperty
   a_idle: assert property (p_idle) else $error("answer without instruction");
   property p_dreg; s_fp ##0 (|(regIsDouble & {regNums[14], regNums[9], regNums[4]})) |=> undefExc; endproperty
   a_dreg: assert property (p_dreg) else $error("high register accepted");
   property p_size; s_fp ##0 (fpOp == FP_CONVERT_INT && size_bit) |=> undefExc && issueOp == ISSUE_NONE; endproperty
   a_size: assert property (p_size) else $error("double conversion accepted");
   property p_misc; s_misc ##0 !(miscOpcode inside {4'h2, 4'h4, 4'h5, 4'h6}) |=> undefExc && !issueValid; endproperty
   a_misc: assert property (p_misc) else $error("unallocated opcode issued");
   property p_barrier;
      s_misc ##0 (miscOpcode == OPC_MEMORY_ORDER) |=>
         issueOp == ISSUE_MEMORY_ORDER && fullSystemBarrier == ($past(barrierOption) == OPTION_FULL_SYSTEM);
   endproperty
   a_barrier: assert property (p_barrier) else $error("order barrier wrong");
   property p_clear; s_misc ##0 (miscOpcode == OPC_CLEAR_EXCLUSIVE) |=> issueOp == ISSUE_CLEAR_EXCLUSIVE; endproperty
   a_clear: assert property (p_clear) else $error("clear exclusive wrong");
   property p_const; sixteen_dreg_variant && !doublePrecSupported; endproperty
   a_const: assert property (p_const) else $error("capability wrong");
endmodule
bind spd_legality_decoder spd_legality_decoder_asserts i_asserts (.core_clk, .rst, .instrValid, .instrClass,
   .fpOp, .size_bit, .regNums, .regIsDouble, .miscOpcode, .barrierOption, .issueValid, .issueOp,
   .fullSystemBarrier, .undefExc, .sixteen_dreg_variant, .doublePrecSupported);
`default_nettype wire

// >>> testbench/spd_exec_model.sv
// execute-side model that tallies issued and refused instructions
`timescale 1ns/1ps
`default_nettype none
module spd_exec_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // from decoder
   input wire logic issueValid,
   input wire logic undefExc,
   // tallies
   output int issued,
   output int undefs
);
   always_ff @(posedge core_clk) begin
      issued <= rst ? 0 : issued + int'(issueValid);
      undefs <= rst ? 0 : undefs + int'(undefExc);
   end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the legality decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import spd_pkg::*;
   logic core_clk, rst, instrValid, size_bit, unsignedFlag, issueValid, fullSystemBarrier, undefExc, sdv, dps;
   spd_class_t instrClass;
   spd_fp_op_t fpOp;
   spd_issue_t issueOp, e;
   logic [1:0] encForm, first_select_field, second_select_field;
   logic [14:0] regNums;
   logic [2:0] regIsDouble;
   logic [3:0] miscOpcode, barrierOption, issueOption;
   int fail_count = 0, samples_checked = 0, expIss = 0, expUnd = 0, gotIss, gotUnd;
   spd_legality_decoder i_spd_legality_decoder (.core_clk, .rst, .instrValid, .instrClass, .fpOp, .encForm,
      .size_bit, .unsignedFlag, .first_select_field, .second_select_field, .regNums, .regIsDouble, .miscOpcode,
      .barrierOption, .issueValid, .issueOp, .issueOption, .fullSystemBarrier, .undefExc,
      .sixteen_dreg_variant(sdv), .doublePrecSupported(dps));
   spd_exec_model i_spd_exec_model (.core_clk, .rst, .issueValid, .undefExc, .issued(gotIss), .undefs(gotUnd));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic bad(input string m);
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   // one instruction in flight, judged one edge later
   task automatic chk(input logic v, input spd_issue_t op);
      @(negedge core_clk);
      samples_checked++;
      expIss += int'(v);
      expUnd += int'(!v);
      if (issueValid !== v || undefExc !== !v || issueOp !== (v ? op : ISSUE_NONE)) bad("issue mismatch");
      if (fullSystemBarrier !== (v && op == ISSUE_MEMORY_ORDER && barrierOption == 4'hF)) bad("barrier flag");
   endtask
   task automatic fp(input spd_fp_op_t op, input logic [1:0] f, input logic s);
      instrValid = 1'b1;
      instrClass = CLASS_FLOAT;
      fpOp = op;
      encForm = f;
      size_bit = s;
      unsignedFlag = 1'b0;
      first_select_field = 2'h0;
      second_select_field = 2'h0;
      regIsDouble = 3'h0;
      regNums = 15'h0;
   endtask
   task automatic t_other;
      @(negedge core_clk);
      if (issueValid !== 1'b0 || undefExc !== 1'b0 || issueOption !== 4'h0) bad("reset outputs");
      instrValid = 1'b1;
      instrClass = CLASS_OTHER;
      chk(1'b1, ISSUE_PASS);
      instrValid = 1'b0;
      @(negedge core_clk);
      if (issueValid !== 1'b0 || undefExc !== 1'b0) bad("idle output");
   endtask
   task automatic t_size;
      spd_fp_op_t ops[4] = '{FP_CONVERT_INT, FP_CONVERT_FIXED, FP_ROUND_DIRECTED, FP_SELECT_COND};
      fp(FP_ADD, FORM_SECOND, 1'b0);
      chk(1'b1, ISSUE_FLOAT);
      fp(FP_ADD, FORM_FIRST, 1'b0);
      chk(1'b0, ISSUE_NONE);
      fp(FP_UNLISTED, FORM_BOTH, 1'b0);
      chk(1'b0, ISSUE_NONE);
      foreach (ops[i]) begin
         fp(ops[i], FORM_FIRST, 1'b0);
         chk(1'b1, ISSUE_FLOAT);
         fp(ops[i], FORM_FIRST, 1'b1);
         chk(1'b0, ISSUE_NONE);
      end
      fp(FP_CONVERT_FIXED, FORM_SECOND, 1'b0);
      chk(1'b0, ISSUE_NONE);
      fp(FP_MUL_ACCUMULATE, FORM_SECOND, 1'b0);
      chk(1'b1, ISSUE_FLOAT);
      fp(FP_MUL_ACCUMULATE, FORM_SECOND, 1'b1);
      chk(1'b0, ISSUE_NONE);
   endtask
   task automatic t_moves;
      spd_fp_op_t mv[3] = '{FP_MOVE_GPR_SINGLE, FP_MOVE_GPR_PAIR_SINGLES, FP_MOVE_GPR_PAIR_DOUBLE};
      fp(FP_MOVE_GPR_TO_SCALAR, FORM_FIRST, 1'b1);
      first_select_field = 2'h1;
      chk(1'b1, ISSUE_FLOAT);
      fp(FP_MOVE_GPR_TO_SCALAR, FORM_FIRST, 1'b0);
      first_select_field = 2'h2;
      chk(1'b0, ISSUE_NONE);
      fp(FP_MOVE_SCALAR_TO_GPR, FORM_FIRST, 1'b0);
      unsignedFlag = 1'b1;
      chk(1'b0, ISSUE_NONE);
      fp(FP_MOVE_SCALAR_TO_GPR, FORM_FIRST, 1'b0);
      second_select_field = 2'h1;
      chk(1'b0, ISSUE_NONE);
      fp(FP_MOVE_SCALAR_TO_GPR, FORM_FIRST, 1'b1);
      first_select_field = 2'h1;
      chk(1'b1, ISSUE_FLOAT);
      foreach (mv[i]) begin
         fp(mv[i], FORM_FIRST, 1'b1);
         first_select_field = 2'h3;
         chk(1'b1, ISSUE_FLOAT);
      end
   endtask
   task automatic t_dreg;
      fp(FP_LOAD_MULTI, FORM_FIRST, 1'b1);
      regIsDouble = 3'h7;
      regNums = {5'h0F, 5'h0F, 5'h0F};
      chk(1'b1, ISSUE_FLOAT);
      for (int i = 0; i < 3; i++) begin
         fp(FP_LOAD_MULTI, FORM_FIRST, 1'b0);
         regIsDouble = 3'h1 << i;
         regNums = 15'h10 << (5 * i);
         chk(1'b0, ISSUE_NONE);
      end
      fp(FP_MOVE_GPR_SINGLE, FORM_FIRST, 1'b0);
      regNums = 15'h7FFF;
      chk(1'b1, ISSUE_FLOAT);
   endtask
   task automatic t_misc;
      for (int k = 0; k < 17; k++) begin
         instrValid = 1'b1;
         instrClass = CLASS_MISC_SYSTEM;
         miscOpcode = (k == 16) ? OPC_MEMORY_ORDER : k[3:0];
         barrierOption = (k == 16) ? 4'h7 : 4'hF;
         e = ISSUE_NONE;
         case (miscOpcode)
            4'h2: e = ISSUE_CLEAR_EXCLUSIVE;
            4'h4: e = ISSUE_DATA_SYNC;
            4'h5: e = ISSUE_MEMORY_ORDER;
            4'h6: e = ISSUE_INSTR_SYNC;
            default: e = ISSUE_NONE;
         endcase
         chk(e != ISSUE_NONE, e);
         if (issueOption !== ((e != ISSUE_NONE) ? barrierOption : 4'h0)) bad("option not carried");
      end
      instrValid = 1'b0;
      // the model counts one edge behind the outputs, so let the last answer reach it
      @(negedge core_clk);
      if (gotIss != expIss || gotUnd != expUnd) bad("execute tally");
      if (sdv !== 1'b1 || dps !== 1'b0) bad("capability outputs");
   endtask
   task automatic close_out;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      fp(FP_ADD, FORM_SECOND, 1'b0);
      instrValid = 1'b0;
      miscOpcode = 4'h0;
      barrierOption = 4'h0;
      rst = 1'b1;
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      t_other();
      t_size();
      t_moves();
      t_dreg();
      t_misc();
      close_out();
   end
endmodule
`default_nettype wire
